// ==== sim/boot_loader_properties.sv ====
// concurrent checks on the boot loader top ports
// assumes one mclk domain with rstn as the only reset
`timescale 1ns/10ps
`default_nettype none
module boot_loader_properties
  import boot_loader_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // observed ports
  input wire straps_t straps,
  input wire logic txd,
  input wire logic txd_oe,
  input wire erase_req_t erase_req,
  input wire ram_wr_t ram_wr,
  input wire op_mode_t op_mode,
  input wire logic [19:0] baud_divisor_reg,
  input wire logic receive_enable_bit,
  input wire logic transmit_enable_bit,
  input wire logic handover
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_start_pulse;
    erase_req.start ##1 !erase_req.start;
  endsequence
  a_mode_user_sel: assert property (op_mode == MODE_USER |-> !straps.test_pin && straps.irq_pin)
    else $error("user mode with wrong straps");
  a_mode_boot_sel: assert property (op_mode == MODE_BOOT |->
    !straps.test_pin && !straps.irq_pin && straps.boot_select_strap)
    else $error("boot mode with wrong straps");
  a_mode_prog_sel: assert property (op_mode == MODE_PROG |-> straps.test_pin &&
    !straps.programmer_strap_0 && !straps.programmer_strap_1 && !straps.programmer_strap_2)
    else $error("programmer mode with wrong straps");
  a_txd_drive_boot: assert property (!txd_oe |-> txd)
    else $error("tx line not idle outside boot mode");
  a_ram_in_window: assert property (ram_wr.wr |-> ram_wr.addr >= RAM_FIRST && ram_wr.addr <= RAM_LAST)
    else $error("load write outside window");
  a_erase_one_pulse: assert property ($rose(erase_req.start) |-> s_start_pulse and op_mode == MODE_BOOT)
    else $error("erase start not a single boot pulse");
  a_handover_quiet: assert property (handover |-> !receive_enable_bit && !transmit_enable_bit && txd && txd_oe)
    else $error("serial not quiet at handover");
  a_divisor_holds: assert property (baud_divisor_reg != 20'h00000 |=> $stable(baud_divisor_reg))
    else $error("divisor changed after match");
endmodule // boot_loader_properties
bind boot_mode_serial_loader boot_loader_properties i_chk (.mclk(mclk), .rstn(rstn), .straps(straps),
  .txd(txd), .txd_oe(txd_oe), .erase_req(erase_req), .ram_wr(ram_wr), .op_mode(op_mode),
  .baud_divisor_reg(baud_divisor_reg), .receive_enable_bit(receive_enable_bit),
  .transmit_enable_bit(transmit_enable_bit), .handover(handover));
`default_nettype wire

// ==== sim/boot_mode_serial_loader_tb_top.sv ====
// self-checking bench for the boot loader
// assumes the host model at 16 mclk cycles per bit
`timescale 1ns/10ps
`default_nettype none
module boot_mode_serial_loader_tb_top;
  import boot_loader_pkg::*;
  // short bit time keeps the run small; a real host rate scales with mclk
  localparam int BT = 16;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic watchdog_overflow = 1'b0;
  logic fail_mode = 1'b0;
  logic rxd, txd, txd_oe, handover, aborted, re_bit, te_bit;
  logic [19:0] div;
  straps_t straps = '0;
  erase_rsp_t erase_rsp = '0;
  erase_req_t erase_req;
  ram_wr_t ram_wr;
  op_mode_t op_mode;
  logic [23:0] wr_q[$];
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int erase_cnt = 0;
  logic [5:0] mode_in[5] = '{6'b010111, 6'b001111, 6'b100000, 6'b000111, 6'b110001};
  op_mode_t mode_exp[5] = '{MODE_USER, MODE_BOOT, MODE_PROG, MODE_NONE, MODE_NONE};

  boot_mode_serial_loader i_dut (.mclk(mclk), .rstn(rstn), .straps(straps),
    .watchdog_overflow(watchdog_overflow), .rxd(rxd), .txd(txd), .txd_oe(txd_oe),
    .erase_req(erase_req), .erase_rsp(erase_rsp), .ram_wr(ram_wr), .op_mode(op_mode),
    .baud_divisor_reg(div), .receive_enable_bit(re_bit), .transmit_enable_bit(te_bit),
    .handover(handover), .aborted(aborted));
  serial_host #(.BT(BT)) i_host (.mclk(mclk), .rxd(rxd), .txd(txd));

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (ram_wr.wr === 1'b1) wr_q.push_back({ram_wr.addr, ram_wr.data});
    if (erase_req.start === 1'b1) erase_cnt++;
    if (cyc == 30000) begin
      err_total++;
      test_done();
    end
  end
  // flash side answers an erase start one cycle later
  always @(negedge mclk) if (erase_req.start === 1'b1) begin
    erase_rsp.done <= 1'b1;
    erase_rsp.fail <= fail_mode;
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  // straps settle while reset is low, well ahead of release
  task automatic do_reset(input logic [5:0] s);
    @(negedge mclk);
    rstn = 1'b0;
    straps = s;
    erase_rsp = '0;
    watchdog_overflow = 1'b0;
    repeat (5) @(negedge mclk);
    i_host.rx_q.delete();
    wr_q.delete();
    erase_cnt = 0;
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
  task automatic expect_rx(input logic [7:0] e, input string what);
    logic [7:0] b;
    for (int t = 0; t < BT * 40 && i_host.rx_q.size() == 0; t++) @(negedge mclk);
    b = (i_host.rx_q.size() != 0) ? i_host.rx_q.pop_front() : 8'hxx;
    check(b, e, what);
  endtask
  // host sends the next byte only after the echo is back
  task automatic xfer(input logic [7:0] b);
    i_host.send(b);
    expect_rx(b, "echo");
  endtask
  task automatic match_baud;
    repeat (SETTLE_CYCLES + 20) @(negedge mclk);
    i_host.send(BYTE_ZERO);
    expect_rx(BYTE_ZERO, "match ack");
    check(div, BT, "divisor");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 5; i++) begin
      do_reset(mode_in[i]);
      check(op_mode, mode_exp[i], "mode select");
    end
    $display("test mode select done");
    do_reset(6'b001000);
    match_baud();
    i_host.send(BYTE_SYNC);
    expect_rx(BYTE_OK, "erase ok");
    check(erase_cnt, 1, "erase pulses");
    xfer(8'h00);
    xfer(8'h03);
    for (int i = 0; i < 3; i++) xfer(8'hc0 + i[7:0]);
    expect_rx(BYTE_OK, "load ok");
    for (int t = 0; t < 2000 && handover !== 1'b1; t++) @(negedge mclk);
    check({handover, re_bit, te_bit, txd, txd_oe}, 5'b10011, "handover state");
    check(div, BT, "divisor kept");
    check(wr_q.size(), 3, "write count");
    for (int i = 0; i < 3; i++) check(wr_q[i], {RAM_FIRST + i[15:0], 8'hc0 + i[7:0]}, "load write");
    $display("test boot load done");
    do_reset(6'b001000);
    fail_mode = 1'b1;
    match_baud();
    i_host.send(BYTE_SYNC);
    expect_rx(BYTE_FAIL, "erase fail");
    check(aborted, 1'b1, "abort on fail");
    fail_mode = 1'b0;
    $display("test erase fail done");
    do_reset(6'b001000);
    erase_rsp.blank = 1'b1;
    match_baud();
    i_host.send(BYTE_SYNC);
    expect_rx(BYTE_OK, "blank ok");
    check(erase_cnt, 0, "no erase when blank");
    xfer(8'h00);
    xfer(8'h00);
    expect_rx(BYTE_OK, "empty load ok");
    for (int t = 0; t < 2000 && handover !== 1'b1; t++) @(negedge mclk);
    check(handover, 1'b1, "empty handover");
    check(wr_q.size(), 0, "no writes");
    $display("test blank flash done");
    do_reset(6'b001000);
    watchdog_overflow = 1'b1;
    repeat (4) @(negedge mclk);
    check(aborted, 1'b1, "watchdog abort");
    check(i_host.rx_q.size(), 0, "silent abort");
    // leaving boot mode takes a long reset with the interrupt pin set before release
    rstn = 1'b0;
    repeat (20) @(negedge mclk);
    do_reset(6'b010000);
    check(op_mode, MODE_USER, "leave boot");
    $display("test boot exit done");
    test_done();
  end
endmodule // boot_mode_serial_loader_tb_top
`default_nettype wire

// ==== sim/serial_host.sv ====
// host model on the boot serial link, sends and collects 8n1 bytes
// assumes rxd has a pull-up, so a released line reads high
`timescale 1ns/10ps
`default_nettype none
module serial_host #(parameter int BT = 16) (
  // clock
  input wire logic mclk,
  // link
  output logic rxd,
  input wire logic txd
);
  logic [7:0] rx_q[$];
  initial rxd = 1'b1;
  // called just after a falling edge; bits change only on falling edges
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd = f[i];
      repeat (BT) @(negedge mclk);
    end
  endtask
  // samples mid-bit; a bad stop bit drops the byte
  always begin : rx_loop
    logic [7:0] b;
    @(negedge txd);
    repeat (BT / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge mclk);
      b[i] = txd;
    end
    repeat (BT) @(posedge mclk);
    if (txd === 1'b1) rx_q.push_back(b);
  end
endmodule // serial_host
`default_nettype wire

// ==== verilog/boot_loader_pkg.sv ====
// constants and carrier types for the boot-mode serial loader
// assumes a single 100 MHz system clock
package boot_loader_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  // settle time before low-period measurement, in system states
  localparam int unsigned SETTLE_STATES = 100;
  localparam int unsigned SETTLE_CYCLES = SETTLE_STATES;
  // a zero byte is start bit plus eight zero data bits
  localparam logic [3:0] LOW_BITS = 4'h9;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_SYNC = 8'h55;
  localparam logic [7:0] BYTE_OK = 8'haa;
  localparam logic [7:0] BYTE_FAIL = 8'hff;
  localparam logic [15:0] RAM_FIRST = 16'hf780;
  localparam logic [15:0] RAM_LAST = 16'hfeef;
  localparam logic [23:0] LOW_MAX = 24'hffffff;
  localparam logic [19:0] DIV_RESET = 20'h00000;

  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_USER = 2'b01,
    MODE_BOOT = 2'b10,
    MODE_PROG = 2'b11
  } op_mode_t;

  typedef struct packed {
    logic test_pin;
    logic irq_pin;
    logic boot_select_strap;
    logic programmer_strap_0;
    logic programmer_strap_1;
    logic programmer_strap_2;
  } straps_t;

  // one write into the load area
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } ram_wr_t;

  // flash erase handshake with the flash control logic
  typedef struct packed {
    logic start;
  } erase_req_t;

  typedef struct packed {
    logic done;
    logic fail;
    logic blank;
  } erase_rsp_t;
endpackage

// ==== verilog/boot_mode_serial_loader.sv ====
// boot-mode selection and serial loader for the on-chip control program
// assumes straps, rx line and flash status are synchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module boot_mode_serial_loader (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // mode straps and watchdog
  input wire boot_loader_pkg::straps_t straps,
  input wire logic watchdog_overflow,
  // serial link
  input wire logic rxd,
  output logic txd,
  output logic txd_oe,
  // flash erase
  output boot_loader_pkg::erase_req_t erase_req,
  input wire boot_loader_pkg::erase_rsp_t erase_rsp,
  // load area and status
  output boot_loader_pkg::ram_wr_t ram_wr,
  output boot_loader_pkg::op_mode_t op_mode,
  output logic [19:0] baud_divisor_reg,
  output logic receive_enable_bit,
  output logic transmit_enable_bit,
  output logic handover,
  output logic aborted
);
  import boot_loader_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta, rst_sync;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  wire logic rst_n = rst_sync;
  ////////////////////////////////////////////////////////////////////////
  // mode latch: sampled on the first clock after release, straps must be settled
  logic mode_taken;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op_mode <= MODE_NONE;
      mode_taken <= 1'b0;
    end else if (!mode_taken) begin
      mode_taken <= 1'b1;
      if (!straps.test_pin && straps.irq_pin) op_mode <= MODE_USER;
      else if (!straps.test_pin && straps.boot_select_strap) op_mode <= MODE_BOOT;
      else if (straps.test_pin && !straps.programmer_strap_0 && !straps.programmer_strap_1
               && !straps.programmer_strap_2) op_mode <= MODE_PROG;
      else op_mode <= MODE_NONE;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // loader sequence
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_SETTLE = 4'b0001, S_WAIT_HIGH = 4'b0010, S_MEASURE = 4'b0011,
    S_SEND_ACK = 4'b0100, S_WAIT_SYNC = 4'b0101, S_ERASE = 4'b0110, S_LEN_HI = 4'b0111,
    S_LEN_LO = 4'b1000, S_DATA = 4'b1001, S_SEND_DONE = 4'b1010, S_RUN = 4'b1011,
    S_ABORT = 4'b1100
  } load_state_t;
  load_state_t state;
  logic [23:0] count;
  logic [15:0] length;
  logic [15:0] load_addr;
  logic rx_valid;
  logic [7:0] rx_data;
  logic tx_busy;
  logic tx_go;
  logic [7:0] tx_byte;
  logic erase_sent;
  // ack, erase-result and load-done bytes wait for a free transmitter; echoes and the blank OK do not
  wire logic tx_free = !tx_busy && !tx_go;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      count <= 24'h000000;
      length <= 16'h0000;
      load_addr <= RAM_FIRST;
      baud_divisor_reg <= DIV_RESET;
      tx_go <= 1'b0;
      tx_byte <= 8'h00;
      ram_wr <= '0;
      erase_req <= '0;
      erase_sent <= 1'b0;
      handover <= 1'b0;
      aborted <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      ram_wr.wr <= 1'b0;
      erase_req.start <= 1'b0;
      // watchdog overflow ends the loader wherever it stands
      if (watchdog_overflow && op_mode == MODE_BOOT) begin
        state <= S_ABORT;
        aborted <= 1'b1;
      end else begin
        case (state)
          S_IDLE: begin
            if (op_mode == MODE_BOOT) state <= S_SETTLE;
            count <= 24'h000000;
          end
          S_SETTLE: begin
            count <= count + 24'h000001;
            if (count >= 24'(SETTLE_CYCLES - 1)) state <= S_WAIT_HIGH;
          end
          S_WAIT_HIGH: begin
            count <= 24'h000000;
            if (!rxd) state <= S_MEASURE;
          end
          S_MEASURE: begin
            if (rxd) begin
              baud_divisor_reg <= 20'((count + 24'h000001) / 24'(LOW_BITS));
              state <= S_SEND_ACK;
            end else if (count != LOW_MAX) count <= count + 24'h000001;
          end
          S_SEND_ACK: begin
            if (tx_free) begin
              tx_byte <= BYTE_ZERO;
              tx_go <= 1'b1;
              state <= S_WAIT_SYNC;
            end
          end
          S_WAIT_SYNC: begin
            // stray zero bytes still in flight are ignored here
            if (rx_valid && rx_data == BYTE_SYNC) begin
              state <= S_ERASE;
              erase_sent <= 1'b0;
            end
          end
          S_ERASE: begin
            if (!erase_sent) begin
              erase_sent <= 1'b1;
              if (erase_rsp.blank) begin
                tx_byte <= BYTE_OK;
                tx_go <= 1'b1;
                state <= S_LEN_HI;
              end else erase_req.start <= 1'b1;
            end else if (erase_rsp.done && tx_free) begin
              tx_byte <= erase_rsp.fail ? BYTE_FAIL : BYTE_OK;
              tx_go <= 1'b1;
              if (erase_rsp.fail) begin
                state <= S_ABORT;
                aborted <= 1'b1;
              end else state <= S_LEN_HI;
            end
          end
          S_LEN_HI: begin
            if (rx_valid) begin
              length[15:8] <= rx_data;
              tx_byte <= rx_data;
              tx_go <= 1'b1;
              state <= S_LEN_LO;
            end
          end
          S_LEN_LO: begin
            if (rx_valid) begin
              length[7:0] <= rx_data;
              tx_byte <= rx_data;
              tx_go <= 1'b1;
              load_addr <= RAM_FIRST;
              state <= ({length[15:8], rx_data} == 16'h0000) ? S_SEND_DONE : S_DATA;
            end
          end
          S_DATA: begin
            if (rx_valid) begin
              tx_byte <= rx_data;
              tx_go <= 1'b1;
              // bytes past the window are echoed but not stored until load_addr wraps to 16'h0000
              ram_wr.wr <= (load_addr <= RAM_LAST);
              ram_wr.addr <= load_addr;
              ram_wr.data <= rx_data;
              load_addr <= load_addr + 16'h0001;
              length <= length - 16'h0001;
              if (length == 16'h0001) state <= S_SEND_DONE;
            end
          end
          S_SEND_DONE: begin
            if (tx_free) begin
              tx_byte <= BYTE_OK;
              tx_go <= 1'b1;
              state <= S_RUN;
            end
          end
          S_RUN: begin
            if (tx_free) handover <= 1'b1;
          end
          S_ABORT: ;
          default: state <= S_IDLE;
        endcase
      end
    end
  end
  // transmit enable drops at handover, receive enable once the done byte is queued; both drop at abort; divisor is kept
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      receive_enable_bit <= 1'b0;
      transmit_enable_bit <= 1'b0;
    end else begin
      receive_enable_bit <= (state >= S_WAIT_SYNC) && (state <= S_SEND_DONE);
      transmit_enable_bit <= (state >= S_SEND_ACK) && (state < S_RUN || (state == S_RUN && tx_busy));
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // receiver: 8 data, 1 stop, no parity, sampled mid-bit
  logic [19:0] rx_cnt;
  logic [3:0] rx_bit;
  logic rx_active;
  logic [7:0] rx_shift;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt <= 20'h00000;
      rx_bit <= 4'h0;
      rx_active <= 1'b0;
      rx_shift <= 8'h00;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_active) begin
        if (receive_enable_bit && !rxd) begin
          rx_active <= 1'b1;
          rx_bit <= 4'h0;
          rx_cnt <= baud_divisor_reg >> 1;
        end
      end else if (rx_cnt != 20'h00000) rx_cnt <= rx_cnt - 20'h00001;
      else begin
        rx_cnt <= baud_divisor_reg - 20'h00001;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rxd) rx_active <= 1'b0; // false start
        else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) rx_shift <= {rxd, rx_shift[7:1]};
        else if (rx_bit == 4'h9) begin
          rx_active <= 1'b0;
          rx_valid <= rxd; // framing error drops the byte
          rx_data <= rx_shift;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // transmitter: start, 8 data lsb first, one stop
  logic [19:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [9:0] tx_frame;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt <= 20'h00000;
      tx_bit <= 4'h0;
      tx_busy <= 1'b0;
      tx_frame <= 10'h3ff;
      txd <= 1'b1;
    end else if (!tx_busy) begin
      txd <= 1'b1;
      if (tx_go) begin
        tx_busy <= 1'b1;
        tx_frame <= {1'b1, tx_byte, 1'b0};
        tx_bit <= 4'h0;
        tx_cnt <= 20'h00000;
      end
    end else if (tx_cnt != 20'h00000) tx_cnt <= tx_cnt - 20'h00001;
    else if (tx_bit == 4'ha) tx_busy <= 1'b0;
    else begin
      txd <= tx_frame[0];
      tx_frame <= {1'b1, tx_frame[9:1]};
      tx_bit <= tx_bit + 4'h1;
      tx_cnt <= baud_divisor_reg - 20'h00001;
    end
  end
  // pin is an output whenever boot mode is selected, carrying the transmitter's frames and idling high
  assign txd_oe = (op_mode == MODE_BOOT);
endmodule // boot_mode_serial_loader
`default_nettype wire
